// [logic/adccsr_pkg.sv]
// package for the converter control and status register bank
// assumes an apb slave with 32-bit data, one word per register

package adccsr_pkg;

  // ************************************************
  // register byte addresses
  // ************************************************
  localparam logic [7:0] ADDR_COMMAND   = 8'h00;
  localparam logic [7:0] ADDR_SETUP     = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_CLEAR     = 8'h0C;
  localparam logic [7:0] ADDR_SEQ_SETUP = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ON    = 8'h30;
  localparam logic [7:0] ADDR_IRQ_OFF   = 8'h34;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h38;

  // ************************************************
  // command bit positions
  // ************************************************
  localparam int CMD_SOFT_RESET = 0;
  localparam int CMD_TIMER_HALT = 1;
  localparam int CMD_TIMER_GO   = 2;
  localparam int CMD_SOFT_TRIG  = 3;
  localparam int CMD_VREF_ON    = 4;
  localparam int CMD_VREF_OFF   = 5;
  localparam int CMD_TURN_ON    = 8;
  localparam int CMD_TURN_OFF   = 9;
  localparam int CMD_BG_ON      = 10;
  localparam int CMD_BG_OFF     = 11;

  // ************************************************
  // setup field positions
  // ************************************************
  localparam int SETUP_VREF_LSB = 1;
  localparam int SETUP_SPD_LSB  = 4;
  localparam int SETUP_CLKSRC   = 6;
  localparam int SETUP_DIV_LSB  = 8;
  localparam logic [31:0] SETUP_MASK   = 32'h0000_077E;
  localparam logic [31:0] SEQ_MASK     = 32'h7077_D7FD;
  localparam int SEQ_TRG_LSB    = 8;
  localparam int SEQ_SHIFT_LSB  = 28;

  // ************************************************
  // status layout
  // ************************************************
  localparam int ST_DONE     = 0;
  localparam int ST_OVERRUN  = 1;
  localparam int ST_WINDOW   = 2;
  localparam int ST_MISSED   = 3;
  localparam int ST_EXPIRED  = 5;
  localparam int ST_READY    = 24;
  localparam int ST_TIMER    = 25;
  localparam int ST_SEQ      = 26;
  localparam int ST_CONV     = 27;
  localparam int ST_VREF     = 28;
  localparam int ST_BANDGAP  = 30;
  localparam logic [4:0] FLAG_W_MASK = 5'h1F;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  localparam logic [2:0] TRG_SOFTWARE = 3'h0;
  localparam logic [2:0] TRG_RESERVED = 3'h7;
  localparam int DIV_BASE_LOG2 = 2;

  // ************************************************
  // carriers
  // ************************************************
  typedef struct packed {
    logic [2:0] clock_divider_sel;
    logic       conv_clock_source;
    logic [1:0] speed_sel;
    logic [2:0] vref_source_sel;
    logic [2:0] shift_level_sel;
    logic [2:0] trigger_source_sel;
  } adccsr_cfg_t;

  typedef struct packed {
    logic conversion_done;
    logic result_overrun;
    logic window_hit;
    logic trigger_missed;
    logic timer_expired;
  } adccsr_evt_t;

endpackage : adccsr_pkg

// [logic/adccsr_regs.sv]
// control and status register bank of the converter interface
// assumes apb master on clk, converter core gives live busy levels and event pulses
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - turn-on/turn-off commands request enable; ready bit reports outcome later.
// - command bits read zero; writing zero does nothing.
// - vref buffer on/off commands set or clear reference buffer.
// - soft trigger command emits one sequencer trigger pulse.
// - timer go/halt start and stop timer; running shown in status.
// - soft reset returns internal state to reset, except flags load that cycle's events; configuration and irq mask kept.
// - divider code 0..7 gives system clock divide 4..512.
// - clock source bit 1 selects bus clock, 0 generic clock.
// - speed code caps rate: 300, 225, 150, 75 ksps.
// - vref select: internal, 0.625 supply, ext1, ext2, 1XX half supply.
// - status shows live converting, sequencer active and timer running bits.
// - ready bit is 1 only once interface is ready after enable.
// - status shows live bandgap request and vref buffer states.
// - timer expired flag sticky until cleared by clear register.
// - trigger missed flag sticky until cleared.
// - window hit flag sticky until cleared.
// - result overrun flag sticky until cleared.
// - conversion done flag sticky until cleared.
// - writing one in clear register clears flag at bits 5,3,2,1,0.
// - shift level select: vref, quarter steps of supply, 0.9 vref.
// - trigger source select: software, timer, internal, continuous, pin edges.
// - irq raised only for masked-in flags; on/off words set/clear mask.
module adccsr_regs #(
  parameter int READY_DELAY = 8
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    converting_flag,
  input  wire logic                    sequencer_active_flag,
  input  wire adccsr_pkg::adccsr_evt_t evt_in,
  output adccsr_pkg::adccsr_cfg_t      cfg_out,
  output logic      [9:0]              clock_divisor,
  output logic                         enable_req,
  output logic                         vref_buffer_on_flag,
  output logic                         bandgap_request_flag,
  output logic                         timer_run_status,
  output logic                         soft_trigger_pulse,
  output logic                         soft_reset_pulse,
  output logic                         irq
);

  // ************************************************
  // bus decode
  // ************************************************
  logic        wr_en;
  logic [31:0] setup_reg;
  logic [31:0] seq_reg;
  logic [4:0]  flags_reg;
  logic [4:0]  mask_reg;
  logic        enable_reg;
  logic        ready_reg;
  logic [7:0]  ready_cnt_reg;
  logic        vref_reg;
  logic        bg_reg;
  logic        timer_reg;
  logic        trig_reg;
  logic        srst_reg;
  logic        known;

  function automatic logic cmd(input logic [31:0] w, input int b);
    cmd = w[b];
  endfunction : cmd

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign known   = hit(paddr, adccsr_pkg::ADDR_COMMAND)   || hit(paddr, adccsr_pkg::ADDR_SETUP)
                || hit(paddr, adccsr_pkg::ADDR_STATUS)    || hit(paddr, adccsr_pkg::ADDR_CLEAR)
                || hit(paddr, adccsr_pkg::ADDR_SEQ_SETUP) || hit(paddr, adccsr_pkg::ADDR_IRQ_ON)
                || hit(paddr, adccsr_pkg::ADDR_IRQ_OFF)   || hit(paddr, adccsr_pkg::ADDR_IRQ_MASK);
  assign pslverr = psel && penable && !known;

  logic cmd_wr;
  assign cmd_wr = wr_en && hit(paddr, adccsr_pkg::ADDR_COMMAND);

  // ************************************************
  // configuration, kept through soft reset
  // ************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_reg <= adccsr_pkg::RESET_WORD;
      seq_reg   <= adccsr_pkg::RESET_WORD;
    end else begin
      if (wr_en && hit(paddr, adccsr_pkg::ADDR_SETUP)) begin
        setup_reg <= pwdata & adccsr_pkg::SETUP_MASK;
      end
      if (wr_en && hit(paddr, adccsr_pkg::ADDR_SEQ_SETUP)) begin
        seq_reg <= pwdata & adccsr_pkg::SEQ_MASK;
      end
    end
  end

  always_comb begin
    cfg_out.clock_divider_sel  = setup_reg[adccsr_pkg::SETUP_DIV_LSB +: 3];
    cfg_out.conv_clock_source  = setup_reg[adccsr_pkg::SETUP_CLKSRC];
    cfg_out.speed_sel          = setup_reg[adccsr_pkg::SETUP_SPD_LSB +: 2];
    cfg_out.vref_source_sel    = setup_reg[adccsr_pkg::SETUP_VREF_LSB +: 3];
    cfg_out.shift_level_sel    = seq_reg[adccsr_pkg::SEQ_SHIFT_LSB +: 3];
    cfg_out.trigger_source_sel = seq_reg[adccsr_pkg::SEQ_TRG_LSB +: 3];
  end

  // divisor 4 shifted left by the code, 4..512
  assign clock_divisor = 10'(1) << (adccsr_pkg::DIV_BASE_LOG2
                         + int'(cfg_out.clock_divider_sel));

  // ************************************************
  // command strobes and internal state
  // ************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      // only a written one acts; zeros are ignored
      trig_reg <= cmd_wr && cmd(pwdata, adccsr_pkg::CMD_SOFT_TRIG);
      srst_reg <= cmd_wr && cmd(pwdata, adccsr_pkg::CMD_SOFT_RESET);
    end
  end
  assign soft_trigger_pulse = trig_reg;
  assign soft_reset_pulse   = srst_reg;

  // internal state; soft reset clears it exactly like the pin reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_reg <= 1'b0;
      vref_reg   <= 1'b0;
      bg_reg     <= 1'b0;
      timer_reg  <= 1'b0;
    end else if (srst_reg) begin
      enable_reg <= 1'b0;
      vref_reg   <= 1'b0;
      bg_reg     <= 1'b0;
      timer_reg  <= 1'b0;
    end else if (cmd_wr) begin
      // off wins when both on and off are written together
      if (cmd(pwdata, adccsr_pkg::CMD_TURN_OFF)) begin
        enable_reg <= 1'b0;
      end else if (cmd(pwdata, adccsr_pkg::CMD_TURN_ON)) begin
        enable_reg <= 1'b1;
      end
      if (cmd(pwdata, adccsr_pkg::CMD_VREF_OFF)) begin
        vref_reg <= 1'b0;
      end else if (cmd(pwdata, adccsr_pkg::CMD_VREF_ON)) begin
        vref_reg <= 1'b1;
      end
      if (cmd(pwdata, adccsr_pkg::CMD_BG_OFF)) begin
        bg_reg <= 1'b0;
      end else if (cmd(pwdata, adccsr_pkg::CMD_BG_ON)) begin
        bg_reg <= 1'b1;
      end
      if (cmd(pwdata, adccsr_pkg::CMD_TIMER_HALT)) begin
        timer_reg <= 1'b0;
      end else if (cmd(pwdata, adccsr_pkg::CMD_TIMER_GO)) begin
        timer_reg <= 1'b1;
      end
    end
  end

  // ready follows enable after a settling count, so software sees it late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_cnt_reg <= 8'h00;
      ready_reg     <= 1'b0;
    end else if (srst_reg || !enable_reg) begin
      ready_cnt_reg <= 8'h00;
      ready_reg     <= 1'b0;
    end else if (ready_cnt_reg == 8'(READY_DELAY)) begin
      ready_reg <= 1'b1;
    end else begin
      ready_cnt_reg <= ready_cnt_reg + 8'h01;
    end
  end

  assign enable_req           = enable_reg;
  assign vref_buffer_on_flag  = vref_reg;
  assign bandgap_request_flag = bg_reg;
  assign timer_run_status     = timer_reg;

  // ************************************************
  // sticky flags and mask
  // ************************************************
  logic [4:0] evt_vec;
  logic [4:0] clr_vec;
  assign evt_vec = {evt_in.timer_expired, evt_in.trigger_missed, evt_in.window_hit,
                    evt_in.result_overrun, evt_in.conversion_done};
  assign clr_vec = (wr_en && hit(paddr, adccsr_pkg::ADDR_CLEAR))
                 ? {pwdata[adccsr_pkg::ST_EXPIRED], pwdata[adccsr_pkg::ST_MISSED],
                    pwdata[adccsr_pkg::ST_WINDOW], pwdata[adccsr_pkg::ST_OVERRUN],
                    pwdata[adccsr_pkg::ST_DONE]} : 5'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= 5'h00;
    end else if (srst_reg) begin
      flags_reg <= evt_vec;
    end else begin
      // set after clear so a coincident event survives
      flags_reg <= (flags_reg & ~clr_vec) | evt_vec;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= 5'h00;
    end else if (wr_en && hit(paddr, adccsr_pkg::ADDR_IRQ_ON)) begin
      mask_reg <= mask_reg | (pwdata[4:0] & adccsr_pkg::FLAG_W_MASK);
    end else if (wr_en && hit(paddr, adccsr_pkg::ADDR_IRQ_OFF)) begin
      mask_reg <= mask_reg & ~(pwdata[4:0] & adccsr_pkg::FLAG_W_MASK);
    end
  end

  assign irq = |(flags_reg & mask_reg);

  // ************************************************
  // read data
  // ************************************************
  function automatic logic [31:0] flag_word(input logic [4:0] f);
    logic [31:0] w;
    w = adccsr_pkg::RESET_WORD;
    w[adccsr_pkg::ST_DONE]    = f[0];
    w[adccsr_pkg::ST_OVERRUN] = f[1];
    w[adccsr_pkg::ST_WINDOW]  = f[2];
    w[adccsr_pkg::ST_MISSED]  = f[3];
    w[adccsr_pkg::ST_EXPIRED] = f[4];
    flag_word = w;
  endfunction : flag_word

  logic [31:0] status_word;
  always_comb begin
    status_word = flag_word(flags_reg);
    status_word[adccsr_pkg::ST_READY]   = ready_reg;
    status_word[adccsr_pkg::ST_TIMER]   = timer_reg;
    status_word[adccsr_pkg::ST_SEQ]     = sequencer_active_flag;
    status_word[adccsr_pkg::ST_CONV]    = converting_flag;
    status_word[adccsr_pkg::ST_VREF]    = vref_reg;
    status_word[adccsr_pkg::ST_BANDGAP] = bg_reg;
  end

  // registered read data, loaded in the setup cycle so it is valid at access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= adccsr_pkg::RESET_WORD;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        adccsr_pkg::ADDR_SETUP:     prdata <= setup_reg;
        adccsr_pkg::ADDR_STATUS:    prdata <= status_word;
        adccsr_pkg::ADDR_SEQ_SETUP: prdata <= seq_reg;
        // mask reads back in the same compressed order it is written
        adccsr_pkg::ADDR_IRQ_MASK:  prdata <= 32'(mask_reg);
        default:                    prdata <= adccsr_pkg::RESET_WORD;
      endcase
    end
  end

endmodule : adccsr_regs

`default_nettype wire

// [sim/adccsr_regs_props.sv]
// port checker for the converter register bank
// assumes a bind onto adccsr_regs, single clock domain
`timescale 1ns/1ns
`default_nettype none
module adccsr_regs_props (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire adccsr_pkg::adccsr_cfg_t cfg_out,
  input wire logic [9:0]              clock_divisor,
  input wire logic                    enable_req,
  input wire logic                    vref_buffer_on_flag,
  input wire logic                    bandgap_request_flag,
  input wire logic                    timer_run_status,
  input wire logic                    soft_trigger_pulse,
  input wire logic                    soft_reset_pulse
);
  // ********************************
  // command write decode
  // ********************************
  logic wr_cmd;
  assign wr_cmd = psel && penable && pwrite && paddr == adccsr_pkg::ADDR_COMMAND;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_div_power: assert property (
    clock_divisor == (10'h004 << cfg_out.clock_divider_sel)) else $error("divisor wrong");
  chk_trig_pulse: assert property (
    wr_cmd && pwdata[3] |=> soft_trigger_pulse ##1 !soft_trigger_pulse) else $error("trig");
  chk_zero_cmd: assert property (wr_cmd && pwdata == 32'h0 |=>
    !soft_trigger_pulse && !soft_reset_pulse && $stable(enable_req)) else $error("zero cmd");
  chk_vref_on: assert property (
    wr_cmd && pwdata[5:4] == 2'h1 && !pwdata[0] |=> vref_buffer_on_flag) else $error("vref on");
  chk_vref_off: assert property (
    wr_cmd && pwdata[5] |=> !vref_buffer_on_flag) else $error("vref off");
  chk_timer_go: assert property (
    wr_cmd && pwdata[2:0] == 3'h4 |=> timer_run_status) else $error("timer go");
  chk_timer_halt: assert property (
    wr_cmd && pwdata[1] |=> !timer_run_status) else $error("timer halt");
  chk_enable_req: assert property (
    wr_cmd && pwdata[9:8] == 2'h1 && !pwdata[0] |=> enable_req) else $error("enable");
  chk_soft_reset: assert property (wr_cmd && pwdata[0] |=> soft_reset_pulse ##1
    !(enable_req || vref_buffer_on_flag || timer_run_status || bandgap_request_flag))
    else $error("soft reset");
  chk_cmd_reads0: assert property (psel && penable && !pwrite &&
    paddr == adccsr_pkg::ADDR_COMMAND |-> prdata == 32'h0) else $error("cmd read");
  cov_enable: cover property (wr_cmd && pwdata[8]);
  cov_reset: cover property (wr_cmd && pwdata[0]);
  cov_trig: cover property (wr_cmd && pwdata[3]);
endmodule : adccsr_regs_props
bind adccsr_regs adccsr_regs_props u_adccsr_regs_props (.clk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .cfg_out, .clock_divisor, .enable_req,
  .vref_buffer_on_flag, .bandgap_request_flag, .timer_run_status, .soft_trigger_pulse,
  .soft_reset_pulse);
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the converter register bank
// assumes apb slave answers with pready, event inputs are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int RDY = 3;
  logic                    clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [7:0]              paddr = 8'h00;
  logic [31:0]             pwdata = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    converting_flag = 1'b0;
  logic                    sequencer_active_flag = 1'b0;
  adccsr_pkg::adccsr_evt_t evt_in = '0;
  adccsr_pkg::adccsr_cfg_t cfg_out;
  logic [9:0]              clock_divisor;
  logic                    enable_req;
  logic                    vref_buffer_on_flag;
  logic                    bandgap_request_flag;
  logic                    timer_run_status;
  logic                    soft_trigger_pulse;
  logic                    soft_reset_pulse;
  logic                    irq;
  logic                    err_seen;
  int                      err_total = 0;
  int                      tests_run = 0;
  adccsr_regs #(.READY_DELAY(RDY)) u_adccsr_regs (.clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .converting_flag, .sequencer_active_flag,
    .evt_in, .cfg_out, .clock_divisor, .enable_req, .vref_buffer_on_flag,
    .bandgap_request_flag, .timer_run_status, .soft_trigger_pulse, .soft_reset_pulse, .irq);
  initial forever #5 clk = ~clk;
  // ********************************
  // shared tasks
  // ********************************
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // ev rides on the access edge so an event can meet a clear
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [4:0] ev, output logic [31:0] r);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    evt_in <= ev;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      test_done();
    end
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    evt_in <= '0;
    #1;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 5'h00, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, 5'h00, r);
  endtask : rd
  // ********************************
  // scenarios
  // ********************************
  task automatic t_regs;
    logic [7:0] ad[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h38};
    logic [31:0] r;
    foreach (ad[i]) begin
      rd(ad[i], r);
      chk("reset value", r, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ad[i], 32'hFFFF_FFFF);
      rd(ad[i], r);
      chk("readback", r, i == 1 ? adccsr_pkg::SETUP_MASK : 32'h0);
    end
    wr(adccsr_pkg::ADDR_SEQ_SETUP, 32'hFFFF_FFFF);
    rd(adccsr_pkg::ADDR_SEQ_SETUP, r);
    chk("seq readback", r, adccsr_pkg::SEQ_MASK);
    rd(8'h10, r);
    chk("unmapped err", err_seen, 1'b1);
  endtask : t_regs
  task automatic t_fields;
    for (int i = 0; i < 8; i++) begin
      wr(adccsr_pkg::ADDR_SETUP, (i << 8) | ((i & 1) << 6) | ((i & 3) << 4) | (i << 1));
      chk("divisor", clock_divisor, 4 << i);
      chk("clock source", cfg_out.conv_clock_source, i & 1);
      chk("speed", cfg_out.speed_sel, i & 3);
      chk("vref select", cfg_out.vref_source_sel, i);
      wr(adccsr_pkg::ADDR_SEQ_SETUP, (i << 28) | (i << 8));
      chk("shift level", cfg_out.shift_level_sel, i);
      chk("trigger source", cfg_out.trigger_source_sel, i);
    end
  endtask : t_fields
  task automatic t_cmd;
    int onb[3] = '{4, 10, 2};
    int offb[3] = '{5, 11, 1};
    int stb[3] = '{28, 30, 25};
    logic [31:0] r;
    wr(adccsr_pkg::ADDR_COMMAND, 1 << 8);
    chk("enable", enable_req, 1'b1);
    rd(adccsr_pkg::ADDR_STATUS, r);
    chk("early ready", r[24], 1'b0);
    repeat (RDY + 2) @(posedge clk);
    rd(adccsr_pkg::ADDR_STATUS, r);
    chk("ready", r[24], 1'b1);
    wr(adccsr_pkg::ADDR_COMMAND, 1 << 9);
    rd(adccsr_pkg::ADDR_STATUS, r);
    chk("disable", {enable_req, r[24]}, 2'h0);
    for (int k = 0; k < 3; k++) begin
      for (int v = 1; v >= 0; v--) begin
        wr(adccsr_pkg::ADDR_COMMAND, 1 << (v ? onb[k] : offb[k]));
        rd(adccsr_pkg::ADDR_STATUS, r);
        chk("state bit", r[stb[k]], v);
        chk("state pin", k == 0 ? vref_buffer_on_flag : k == 1 ? bandgap_request_flag
            : timer_run_status, v);
      end
    end
    @(posedge clk);
    converting_flag <= 1'b1;
    rd(adccsr_pkg::ADDR_STATUS, r);
    chk("conv busy", r[27:26], 2'h2);
    @(posedge clk);
    converting_flag <= 1'b0;
    sequencer_active_flag <= 1'b1;
    rd(adccsr_pkg::ADDR_STATUS, r);
    chk("seq busy", r[27:26], 2'h1);
    @(posedge clk);
    sequencer_active_flag <= 1'b0;
    wr(adccsr_pkg::ADDR_COMMAND, 1 << 3);
    chk("trig pulse", soft_trigger_pulse, 1'b1);
    @(posedge clk);
    #1;
    chk("trig single", soft_trigger_pulse, 1'b0);
    wr(adccsr_pkg::ADDR_COMMAND, 32'h0);
    chk("zero write", {soft_trigger_pulse, soft_reset_pulse}, 2'h0);
  endtask : t_cmd
  task automatic t_flags;
    int sp[5] = '{0, 1, 2, 3, 5};
    logic [31:0] r;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      evt_in <= 5'h10 >> k;
      @(posedge clk);
      evt_in <= '0;
      rd(adccsr_pkg::ADDR_STATUS, r);
      chk("flag set", r[sp[k]], 1'b1);
      chk("irq masked", irq, 1'b0);
      wr(adccsr_pkg::ADDR_IRQ_ON, 1 << k);
      rd(adccsr_pkg::ADDR_IRQ_MASK, r);
      chk("mask", r, 32'h1 << k);
      chk("irq on", irq, 1'b1);
      wr(adccsr_pkg::ADDR_IRQ_OFF, 1 << k);
      chk("irq off", irq, 1'b0);
      wr(adccsr_pkg::ADDR_CLEAR, ~(32'h1 << sp[k]));
      rd(adccsr_pkg::ADDR_STATUS, r);
      chk("zero clear", r[sp[k]], 1'b1);
      apb(1'b1, adccsr_pkg::ADDR_CLEAR, 1 << sp[k], 5'h10 >> k, r);
      rd(adccsr_pkg::ADDR_STATUS, r);
      chk("set wins", r[sp[k]], 1'b1);
      wr(adccsr_pkg::ADDR_CLEAR, 1 << sp[k]);
      rd(adccsr_pkg::ADDR_STATUS, r);
      chk("cleared", r[5:0], 6'h00);
    end
  endtask : t_flags
  task automatic t_soft_reset_cmd;
    logic [31:0] r;
    wr(adccsr_pkg::ADDR_SETUP, 32'h0000_0256);
    wr(adccsr_pkg::ADDR_COMMAND, 32'h0000_0514);
    @(posedge clk);
    evt_in <= 5'h10;
    wr(adccsr_pkg::ADDR_COMMAND, 32'h1);
    chk("reset pulse", soft_reset_pulse, 1'b1);
    @(posedge clk);
    #1;
    rd(adccsr_pkg::ADDR_STATUS, r);
    chk("state cleared", r, 32'h0);
    chk("state pins", {enable_req, vref_buffer_on_flag, timer_run_status}, 3'h0);
    rd(adccsr_pkg::ADDR_SETUP, r);
    chk("setup kept", r, 32'h0000_0256);
  endtask : t_soft_reset_cmd
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_fields();
    t_cmd();
    t_flags();
    t_soft_reset_cmd();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
